//--- rtk_regs.svh
`ifndef RTK_REGS_SVH
`define RTK_REGS_SVH
`define RTK_ADR_FLAGS 4'h0
`define RTK_ADR_CENT 4'h1
`define RTK_ADR_CAL 4'h8
`define RTK_ADR_SEC 4'h9
`define RTK_ADR_MIN 4'ha
`define RTK_FLG_R 0
`define RTK_FLG_W 1
`define RTK_FLG_CAL 2
`define RTK_FLG_OSCILLATOR_FAIL_FLAG 4
`define RTK_FLG_AF 6
`define RTK_FLG_WDF 7
`define RTK_CAL_OSCDIS 7
`define RTK_RST_ZERO 8'h00
`define RTK_RST_ONE 8'h01
`define RTK_TOP_SEC 8'h59
`define RTK_TOP_HOUR 8'h23
`define RTK_TOP_DOW 8'h07
`define RTK_TOP_MON 8'h12
`define RTK_TOP_YEAR 8'h99
`define RTK_OP_RTC_RD 8'h13
`define RTK_OP_RTC_WR 8'h12
`define RTK_OP_STORE 8'h3c
`define RTK_CLK_HZ 20000000
`define RTK_OSCILLATOR_FAIL_FLAG_WAIT_US 5000
`define RTK_OSCILLATOR_FAIL_FLAG_WAIT_CYC (`RTK_OSCILLATOR_FAIL_FLAG_WAIT_US * (`RTK_CLK_HZ / 1000000))
`define RTK_OSC_DIV 32768
`endif

//--- rtk_pkg.sv
package rtk_pkg;
   typedef logic [7:0] rtk_byte_t;
   typedef enum logic [1:0] {
      PH_OPC = 2'b00,
      PH_ADR = 2'b01,
      PH_DAT = 2'b10,
      PH_IGN = 2'b11
   } rtk_phase_t;
endpackage

//--- rtk_timekeeper.sv
`timescale 1ns/100ps
`include "rtk_regs.svh"
module rtk_timekeeper #(
   parameter int OSCILLATOR_FAIL_FLAG_WAIT = `RTK_OSCILLATOR_FAIL_FLAG_WAIT_CYC,
   parameter int OSC_DIV = `RTK_OSC_DIV
) (
   input wire logic CLOCK_IN,
   input wire logic SYS_RST_IN,
   input wire logic SPI_CS_N_IN,
   input wire logic SPI_SCK_IN,
   input wire logic SPI_SI_IN,
   output logic SPI_SO_OUT,
   output logic SPI_SO_OE_OUT,
   input wire logic OSC_CLK_IN,
   input wire logic SUPPLY_OK_IN,
   output logic OSC_ENABLE_OUT
);
   localparam int DW = $clog2(OSC_DIV);
   localparam int WW = $clog2(OSCILLATOR_FAIL_FLAG_WAIT + 1);

   // Refuse counts the counters cannot serve
   if (OSC_DIV < 2 || OSCILLATOR_FAIL_FLAG_WAIT < 1) begin : g_bad
      $error("rtk_timekeeper: OSC_DIV or OSCILLATOR_FAIL_FLAG_WAIT too small");
   end

   logic [4:0] sync1_q, sync2_q, sync3_q;
   logic [2:0] bit_q;
   logic [7:0] rx_q, tx_q, flags_q, fl_seen_q;
   logic [3:0] adr_q;
   logic rd_q, skip_q, w_dly_q, chk_q, fl_out_q;
   rtk_pkg::rtk_phase_t ph_q;
   rtk_pkg::rtk_byte_t usr_q [1:15];
   rtk_pkg::rtk_byte_t cnt_q [0:7];
   rtk_pkg::rtk_byte_t base_q [0:7];
   rtk_pkg::rtk_byte_t nxt [0:7];
   logic [DW-1:0] div_q;
   logic [WW-1:0] wait_q;

   // Time entry k lives at this register address
   function automatic logic [3:0] tadr(input int k);
      return (k == 0) ? `RTK_ADR_CENT : 4'(8 + k);
   endfunction

   // One BCD step; carry out only on reaching top
   function automatic logic [8:0] step(input logic [7:0] v, input logic [7:0] top,
                                       input logic [7:0] bot, input logic en);
      if (!en)
         return {1'b0, v};
      else if (v == top)
         return {1'b1, bot};
      else if (v[3:0] == 4'h9)
         return {1'b0, v[7:4] + 4'h1, 4'h0};
      else
         return {1'b0, v[7:4], v[3:0] + 4'h1};
   endfunction

   // Divisible by four, for a BCD byte
   function automatic logic div4(input logic [7:0] b);
      if (b[4])
         return b[3:0] == 4'h2 || b[3:0] == 4'h6;
      else
         return b[3:0] == 4'h0 || b[3:0] == 4'h4 || b[3:0] == 4'h8;
   endfunction

   // Pins pass two flops; the third only feeds edge finders
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         sync1_q <= 5'h01;
         sync2_q <= 5'h01;
         sync3_q <= 5'h01;
      end else begin
         sync1_q <= {SUPPLY_OK_IN, OSC_CLK_IN, SPI_SI_IN, SPI_SCK_IN, SPI_CS_N_IN};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   wire cs_n = sync2_q[0];
   wire si = sync2_q[2];
   wire sck_rise = sync2_q[1] && !sync3_q[1];
   wire sck_fall = !sync2_q[1] && sync3_q[1];
   wire osc_rise = sync2_q[3] && !sync3_q[3];
   wire sup_rise = sync2_q[4] && !sync3_q[4];

   // Serial byte assembly and strobes
   wire [7:0] rx_byte = {rx_q[6:0], si};
   wire byte_done = !cs_n && sck_rise && bit_q == 3'h7;
   wire [3:0] ld_adr = (ph_q == rtk_pkg::PH_ADR) ? rx_byte[3:0] : adr_q;
   wire rd_ld = byte_done && rd_q && (ph_q == rtk_pkg::PH_ADR || ph_q == rtk_pkg::PH_DAT);
   wire wr_stb = byte_done && !rd_q && ph_q == rtk_pkg::PH_DAT;
   wire rd_act = !cs_n && rd_q;
   wire flag_wr = wr_stb && adr_q == `RTK_ADR_FLAGS;
   // Flags clear once their byte is fully shifted out, not when merely prefetched
   wire flag_rd = byte_done && rd_q && ph_q == rtk_pkg::PH_DAT && fl_out_q;
   wire reg_wr = wr_stb && adr_q != `RTK_ADR_FLAGS && flags_q[`RTK_FLG_W];
   wire [7:0] rd_val = (ld_adr == `RTK_ADR_FLAGS) ? flags_q : usr_q[ld_adr];
   wire commit = w_dly_q && !flags_q[`RTK_FLG_W];
   wire refresh = !flags_q[`RTK_FLG_R] && !flags_q[`RTK_FLG_W] && !rd_act;
   wire sec_tick = osc_rise && div_q == DW'(OSC_DIV - 1);
   wire oscillator_fail_flag_set = chk_q && !osc_rise && wait_q == WW'(OSCILLATOR_FAIL_FLAG_WAIT - 1);

   // Sequence phase; address wraps inside the 16 RTC registers
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         ph_q <= rtk_pkg::PH_OPC;
         bit_q <= 3'h0;
         rx_q <= 8'h00;
         rd_q <= 1'b0;
         adr_q <= 4'h0;
      end else if (cs_n) begin
         ph_q <= rtk_pkg::PH_OPC;
         bit_q <= 3'h0;
         rd_q <= 1'b0;
      end else if (sck_rise) begin
         bit_q <= bit_q + 3'h1;
         rx_q <= rx_byte;
         if (bit_q == 3'h7) begin
            unique case (ph_q)
               rtk_pkg::PH_OPC: begin
                  rd_q <= rx_byte == `RTK_OP_RTC_RD;
                  if (rx_byte == `RTK_OP_RTC_RD || rx_byte == `RTK_OP_RTC_WR)
                     ph_q <= rtk_pkg::PH_ADR;
                  else
                     ph_q <= rtk_pkg::PH_IGN;
               end
               rtk_pkg::PH_ADR: begin
                  ph_q <= rtk_pkg::PH_DAT;
                  adr_q <= rd_q ? rx_byte[3:0] + 4'h1 : rx_byte[3:0];
               end
               rtk_pkg::PH_DAT: begin
                  adr_q <= adr_q + 4'h1;
               end
               rtk_pkg::PH_IGN: begin
                  ph_q <= rtk_pkg::PH_IGN;
               end
            endcase
         end
      end
   end

   // Read data shifts out on falling edges; first bit stands at load
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         tx_q <= 8'h00;
         skip_q <= 1'b0;
         SPI_SO_OUT <= 1'b0;
         SPI_SO_OE_OUT <= 1'b0;
         fl_out_q <= 1'b0;
         fl_seen_q <= 8'h00;
      end else begin
         SPI_SO_OUT <= tx_q[7];
         if (cs_n) begin
            SPI_SO_OE_OUT <= 1'b0;
            fl_out_q <= 1'b0;
         end else if (rd_ld) begin
            SPI_SO_OE_OUT <= 1'b1;
         end
         if (rd_ld) begin
            tx_q <= rd_val;
            skip_q <= 1'b1;
            fl_out_q <= ld_adr == `RTK_ADR_FLAGS; // Flags byte now on its way out
            fl_seen_q <= rd_val;
         end else if (sck_fall && !cs_n) begin
            skip_q <= 1'b0;
            if (!skip_q)
               tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // Flags: hardware set wins over any clear in the same cycle
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         flags_q <= `RTK_RST_ZERO;
         w_dly_q <= 1'b0;
      end else begin
         w_dly_q <= flags_q[`RTK_FLG_W];
         if (flag_wr) begin
            flags_q[`RTK_FLG_R] <= rx_byte[`RTK_FLG_R];
            flags_q[`RTK_FLG_W] <= rx_byte[`RTK_FLG_W];
            if (flags_q[`RTK_FLG_W]) begin
               flags_q[`RTK_FLG_CAL] <= rx_byte[`RTK_FLG_CAL];
               flags_q[`RTK_FLG_OSCILLATOR_FAIL_FLAG] <= rx_byte[`RTK_FLG_OSCILLATOR_FAIL_FLAG];
               flags_q[`RTK_FLG_AF] <= rx_byte[`RTK_FLG_AF];
               flags_q[`RTK_FLG_WDF] <= rx_byte[`RTK_FLG_WDF];
            end
         end
         if (flag_rd) begin
            flags_q[`RTK_FLG_OSCILLATOR_FAIL_FLAG] <= flags_q[`RTK_FLG_OSCILLATOR_FAIL_FLAG] && !fl_seen_q[`RTK_FLG_OSCILLATOR_FAIL_FLAG];
            flags_q[`RTK_FLG_AF] <= flags_q[`RTK_FLG_AF] && !fl_seen_q[`RTK_FLG_AF];
            flags_q[`RTK_FLG_WDF] <= flags_q[`RTK_FLG_WDF] && !fl_seen_q[`RTK_FLG_WDF];
         end
         if (oscillator_fail_flag_set)
            flags_q[`RTK_FLG_OSCILLATOR_FAIL_FLAG] <= 1'b1;
      end
   end

   // Seconds prescaler on oscillator edges; stopped oscillator stops time
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN)
         div_q <= '0;
      else if (sec_tick)
         div_q <= '0;
      else if (osc_rise)
         div_q <= div_q + DW'(1);
   end

   // Power-up watch: any oscillator rising edge inside the window passes
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         chk_q <= 1'b0;
         wait_q <= '0;
      end else if (sup_rise && OSC_ENABLE_OUT) begin
         chk_q <= 1'b1;
         wait_q <= '0;
      end else if (chk_q) begin
         wait_q <= wait_q + WW'(1);
         if (osc_rise || oscillator_fail_flag_set)
            chk_q <= 1'b0;
      end
   end

   // Next count; each field carries only from an exact top value
   always_comb begin
      logic [8:0] r;
      logic c, day;
      logic [7:0] dim;
      r = 9'h000;
      c = 1'b0;
      day = 1'b0;
      dim = 8'h31;
      for (int k = 0; k < 8; k++)
         nxt[k] = cnt_q[k];
      r = step(cnt_q[1], `RTK_TOP_SEC, `RTK_RST_ZERO, sec_tick);
      nxt[1] = r[7:0];
      r = step(cnt_q[2], `RTK_TOP_SEC, `RTK_RST_ZERO, r[8]);
      nxt[2] = r[7:0];
      r = step(cnt_q[3], `RTK_TOP_HOUR, `RTK_RST_ZERO, r[8]);
      nxt[3] = r[7:0];
      day = r[8];
      r = step(cnt_q[4], `RTK_TOP_DOW, `RTK_RST_ONE, day);
      nxt[4] = r[7:0];
      // Month length, leap from year or from century at 00
      if (cnt_q[6] == 8'h02)
         dim = div4(cnt_q[7] == 8'h00 ? cnt_q[0] : cnt_q[7]) ? 8'h29 : 8'h28;
      else if (cnt_q[6] == 8'h04 || cnt_q[6] == 8'h06 || cnt_q[6] == 8'h09 ||
               cnt_q[6] == 8'h11)
         dim = 8'h30;
      r = step(cnt_q[5], dim, `RTK_RST_ONE, day);
      nxt[5] = r[7:0];
      r = step(cnt_q[6], `RTK_TOP_MON, `RTK_RST_ONE, r[8]);
      nxt[6] = r[7:0];
      r = step(cnt_q[7], `RTK_TOP_YEAR, `RTK_RST_ZERO, r[8]);
      nxt[7] = r[7:0];
      c = r[8];
      r = step(cnt_q[0], `RTK_TOP_YEAR, `RTK_RST_ZERO, c);
      nxt[0] = r[7:0];
   end

   // Running counters never stop for host access
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         for (int k = 0; k < 8; k++)
            cnt_q[k] <= (k >= 4 && k <= 6) ? `RTK_RST_ONE : `RTK_RST_ZERO;
      end else if (oscillator_fail_flag_set) begin
         for (int k = 0; k < 8; k++)
            cnt_q[k] <= base_q[k];
      end else if (commit) begin
         for (int k = 0; k < 8; k++)
            cnt_q[k] <= usr_q[tadr(k)];
      end else begin
         for (int k = 0; k < 8; k++)
            cnt_q[k] <= nxt[k];
      end
   end

   // Base time is captured at each commit
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         for (int k = 0; k < 8; k++)
            base_q[k] <= (k >= 4 && k <= 6) ? `RTK_RST_ONE : `RTK_RST_ZERO;
      end else if (commit) begin
         for (int k = 0; k < 8; k++)
            base_q[k] <= usr_q[tadr(k)];
      end
   end

   // User copies; calibration is left alone on oscillator fail
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         for (int i = 1; i < 16; i++)
            usr_q[i] <= (i >= 12 && i <= 14) ? `RTK_RST_ONE : `RTK_RST_ZERO;
      end else begin
         if (refresh) begin
            for (int k = 0; k < 8; k++)
               usr_q[tadr(k)] <= cnt_q[k];
         end
         if (reg_wr)
            usr_q[adr_q] <= rx_byte;
      end
   end

   // Drive oscillator on unless the disable bit is one
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN)
         OSC_ENABLE_OUT <= 1'b1;
      else
         OSC_ENABLE_OUT <= !usr_q[`RTK_ADR_CAL][`RTK_CAL_OSCDIS];
   end

   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (SYS_RST_IN);

   chk_freeze_hold: assert property (flags_q[`RTK_FLG_R] && !reg_wr |=>
      $stable(usr_q[`RTK_ADR_SEC])) else $error("user seconds moved while frozen");
   chk_refresh_copy: assert property (refresh && !reg_wr |=>
      usr_q[`RTK_ADR_SEC] == $past(cnt_q[1])) else $error("user copy not refreshed");
   chk_commit_load: assert property (commit && !oscillator_fail_flag_set |=>
      cnt_q[1] == $past(usr_q[`RTK_ADR_SEC])) else $error("commit did not load counter");
   chk_base_save: assert property (commit |=>
      base_q[2] == $past(usr_q[`RTK_ADR_MIN])) else $error("base time not saved");
   chk_oscillator_fail_flag_reload: assert property (oscillator_fail_flag_set |=> flags_q[`RTK_FLG_OSCILLATOR_FAIL_FLAG] &&
      cnt_q[1] == $past(base_q[1])) else $error("fail did not reload base");
   chk_oscillator_fail_flag_window: assert property (sup_rise && OSC_ENABLE_OUT && !sync2_q[3] |=>
      chk_q) else $error("oscillator check not started");
   chk_read_clear: assert property (flag_rd && !oscillator_fail_flag_set |=>
      !(flags_q[`RTK_FLG_OSCILLATOR_FAIL_FLAG] && $past(fl_seen_q[`RTK_FLG_OSCILLATOR_FAIL_FLAG])) &&
      !(flags_q[`RTK_FLG_AF] && $past(fl_seen_q[`RTK_FLG_AF]))) else $error("flags not cleared");
   chk_flag_lock: assert property (flag_wr && !flags_q[`RTK_FLG_W] |=>
      $stable(flags_q[`RTK_FLG_CAL])) else $error("locked flag bit changed");
   chk_sec_wrap: assert property (sec_tick && cnt_q[1] == 8'h59 && !commit && !oscillator_fail_flag_set |=>
      cnt_q[1] == 8'h00 && cnt_q[2] != $past(cnt_q[2])) else $error("bad second wrap");
   chk_bad_nibble: assert property (sec_tick && cnt_q[1][3:0] == 4'hf && !commit &&
      !oscillator_fail_flag_set |=> cnt_q[1][3:0] == 4'h0) else $error("invalid nibble no wrap");
   chk_osc_enable: assert property (!usr_q[`RTK_ADR_CAL][`RTK_CAL_OSCDIS] |=>
      OSC_ENABLE_OUT) else $error("oscillator not enabled");

   cov_commit: cover property (commit);
   cov_oscillator_fail_flag: cover property (oscillator_fail_flag_set);
   cov_flag_read: cover property (flag_rd);
   cov_minute: cover property (sec_tick && cnt_q[1] == 8'h59);
endmodule

//--- rtk_spi_host.sv
`timescale 1ns/100ps
module rtk_spi_host (
   input wire logic clk_in,
   input wire logic so_in,
   output logic cs_n_out,
   output logic sck_out,
   output logic si_out
);
   rtk_pkg::rtk_byte_t data [16];
   // Deselected at time zero; the serial clock stands low between frames
   initial begin
      cs_n_out = 1'b1;
      sck_out = 1'b0;
      si_out = 1'b0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // Opcode, address, n data bytes, MSB first; read bytes replace data[] in place
   task automatic frame(input rtk_pkg::rtk_byte_t opc, input rtk_pkg::rtk_byte_t adr,
                        input int n);
      rtk_pkg::rtk_byte_t tx;
      step(1);
      cs_n_out = 1'b0;
      step(4);
      for (int b = -2; b < n; b++) begin
         tx = (b == -2) ? opc : ((b == -1) ? adr : data[b]);
         for (int i = 7; i >= 0; i--) begin
            si_out = tx[i];
            step(4);
            if (b >= 0) data[b][i] = so_in; // Taken as the rising edge goes out
            sck_out = 1'b1;
            step(4);
            sck_out = 1'b0;
         end
      end
      step(4);
      cs_n_out = 1'b1;
      si_out = ~si_out; // Released line must not look like held data
      step(8);
   endtask
endmodule

//--- rtk_timekeeper_tb_top.sv
`timescale 1ns/100ps
`include "rtk_regs.svh"
module rtk_timekeeper_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic osc = 1'b0;
   logic supply = 1'b1;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe;
   logic osc_en;
   int num_errors = 0;
   int n_tests = 0;
   logic oe_seen = 1'b0;
   // Century, then seconds to year as written, then the same after nt oscillator rises
   logic [127:0] vec [3] = '{128'h20_59_59_23_07_31_12_99_21_00_00_00_01_01_01_00,
                            128'h20_59_59_23_03_28_02_24_20_00_00_00_04_29_02_24,
                            128'h20_0e_00_00_01_01_01_00_20_00_00_00_01_01_01_00};
   int nt [3] = '{4, 4, 8};
   always #25 clk = ~clk;
   // Remembers that the data-out driver was switched on at least once
   always @(posedge clk) if (so_oe) oe_seen <= 1'b1;
   // Short fail window and divider keep the run brief
   rtk_timekeeper #(.OSCILLATOR_FAIL_FLAG_WAIT(50), .OSC_DIV(4)) i_dut (
      .CLOCK_IN(clk),
      .SYS_RST_IN(rst),
      .SPI_CS_N_IN(cs_n),
      .SPI_SCK_IN(sck),
      .SPI_SI_IN(si),
      .SPI_SO_OUT(so),
      .SPI_SO_OE_OUT(so_oe),
      .OSC_CLK_IN(osc),
      .SUPPLY_OK_IN(supply),
      .OSC_ENABLE_OUT(osc_en)
   );
   rtk_spi_host i_host (.clk_in(clk), .so_in(so), .cs_n_out(cs_n), .sck_out(sck), .si_out(si));
   task automatic tally_and_finish;
      if (num_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input rtk_pkg::rtk_byte_t exp,
                      input rtk_pkg::rtk_byte_t got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] adr, input rtk_pkg::rtk_byte_t val);
      i_host.data[0] = val;
      i_host.frame(`RTK_OP_RTC_WR, {4'h0, adr}, 1);
   endtask
   task automatic rdc(input string what, input logic [3:0] adr, input rtk_pkg::rtk_byte_t exp);
      i_host.frame(`RTK_OP_RTC_RD, {4'h0, adr}, 1);
      chk(what, exp, i_host.data[0]);
   endtask
   // Burst read of seconds to year relies on address auto-increment
   task automatic chk_time(input logic [55:0] exp);
      i_host.frame(`RTK_OP_RTC_RD, 8'h09, 7);
      for (int k = 0; k < 7; k++) chk("time byte", exp[55-8*k -: 8], i_host.data[k]);
   endtask
   // Rises come in multiples of the divider so the prescaler phase never matters
   task automatic osc_rises(input int n);
      repeat (n) begin
         @(posedge clk);
         #1 osc = 1'b1;
         repeat (10) @(posedge clk);
         #1 osc = 1'b0;
         repeat (9) @(posedge clk);
      end
   endtask
   task automatic supply_bounce;
      @(posedge clk);
      #1 supply = 1'b0;
      repeat (5) @(posedge clk);
      #1 supply = 1'b1;
   endtask
   // Hang guard: a run this long counts as a failure
   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      repeat (60) @(posedge clk);
      #1;
      rdc("year before flags", 4'hf, 8'h00);
      rdc("flags after silent start", `RTK_ADR_FLAGS, 8'h10);
      chk("data out driven", 8'h01, {7'h00, oe_seen});
      rdc("flags after read", `RTK_ADR_FLAGS, 8'h00);
      chk("data out enable", 8'h00, {7'h00, so_oe});
      rdc("calibration", `RTK_ADR_CAL, 8'h00);
      chk("oscillator enable", 8'h01, {7'h00, osc_en});
      chk_time(vec[2][55:0]);
      for (int r = 0; r < 3; r++) begin
         wr(`RTK_ADR_FLAGS, 8'h02);
         wr(`RTK_ADR_CENT, vec[r][127:120]);
         for (int k = 0; k < 7; k++) i_host.data[k] = vec[r][119-8*k -: 8];
         i_host.frame(`RTK_OP_RTC_WR, 8'h09, 7);
         wr(`RTK_ADR_FLAGS, 8'h00);
         rdc("seconds loaded", `RTK_ADR_SEC, vec[r][119:112]);
         osc_rises(nt[r]);
         rdc("century", `RTK_ADR_CENT, vec[r][63:56]);
         chk_time(vec[r][55:0]);
      end
      // Freeze holds the user copy while the counters keep going
      wr(`RTK_ADR_FLAGS, 8'h01);
      osc_rises(4);
      rdc("frozen seconds", `RTK_ADR_SEC, 8'h00);
      wr(`RTK_ADR_FLAGS, 8'h00);
      rdc("refreshed seconds", `RTK_ADR_SEC, 8'h01);
      // Register writes and flag writes beyond R and W without the unlock bit are dropped
      wr(`RTK_ADR_FLAGS, 8'h02);
      wr(4'h3, 8'h5a);
      wr(`RTK_ADR_FLAGS, 8'h06);
      wr(`RTK_ADR_FLAGS, 8'h04);
      wr(4'h3, 8'ha5);
      rdc("storage", 4'h3, 8'h5a);
      wr(`RTK_ADR_FLAGS, 8'h00);
      rdc("flags locked", `RTK_ADR_FLAGS, 8'h04);
      wr(`RTK_ADR_FLAGS, 8'h02);
      wr(`RTK_ADR_CAL, 8'h80);
      chk("oscillator stopped", 8'h00, {7'h00, osc_en});
      rdc("calibration", `RTK_ADR_CAL, 8'h80);
      wr(`RTK_ADR_CAL, 8'h05);
      chk("oscillator running", 8'h01, {7'h00, osc_en});
      wr(`RTK_ADR_FLAGS, 8'h00);
      // Persist the committed clock; the timekeeper itself ignores this opcode
      i_host.frame(`RTK_OP_STORE, 8'h00, 0);
      // Silent oscillator after supply returns reloads the base time
      osc_rises(8);
      supply_bounce();
      repeat (80) @(posedge clk);
      #1;
      rdc("fail flag", `RTK_ADR_FLAGS, 8'h10);
      rdc("base seconds", `RTK_ADR_SEC, 8'h01);
      rdc("calibration kept", `RTK_ADR_CAL, 8'h05);
      rdc("flags cleared", `RTK_ADR_FLAGS, 8'h00);
      supply_bounce();
      osc_rises(4);
      rdc("flags healthy", `RTK_ADR_FLAGS, 8'h00);
      rdc("seconds on", `RTK_ADR_SEC, 8'h02);
      tally_and_finish();
   end
endmodule
